// >>> alert_route_consts.svh
/*
 constants for the pin-one alert routing mask: offset, field positions,
 reset value, pulse timing. assumes a 40 MHz core clock.
*/
`ifndef ALERT_ROUTE_CONSTS_SVH
`define ALERT_ROUTE_CONSTS_SVH
`define ROUTE_MASK_OFFSET 8'h27
`define ROUTE_MASK_WIDTH 24
`define ROUTE_MASK_RESET 24'h000000
`define ROUTE_MASK_IMPL 24'hFFFFFE
`define ROUTE_OC_HI 23
`define ROUTE_OC_LO 20
`define ROUTE_UC_HI 19
`define ROUTE_UC_LO 16
`define ROUTE_OV_HI 15
`define ROUTE_OV_LO 12
`define ROUTE_UV_HI 11
`define ROUTE_UV_LO 8
`define ROUTE_OP_HI 7
`define ROUTE_OP_LO 4
`define ROUTE_ACC_FULL_BIT 3
`define ROUTE_COUNT_FULL_BIT 2
`define ROUTE_CONV_DONE_BIT 1
`define CLK_PERIOD_NS 25
`define CONV_PULSE_US 5
`define CONV_PULSE_CYCLES ((`CONV_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define PULSE_CNT_WIDTH 8
`endif

// >>> alert_route_pkg.sv
/*
 types for the pin-one alert routing mask.
 assumes alert_route_consts.svh supplies the widths.
*/
`include "alert_route_consts.svh"
package alert_route_pkg;
    // tripped alert sources, laid out as the mask bits
    typedef struct packed {
        logic [3:0] overcurrent;
        logic [3:0] undercurrent;
        logic [3:0] overvoltage;
        logic [3:0] undervoltage;
        logic [3:0] overpower;
        logic accumulator_full;
        logic sample_count_full;
    } alert_src_type;
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [23:0] wdata;
    } reg_req_type;
    typedef enum logic [1:0] {
        pulse_idle = 2'b00,
        pulse_high = 2'b01
    } pulse_state_type;
endpackage

// >>> alert_pin_one_routing_mask.sv
/*
 alert routing mask for multifunction pin one: mask register, gating of
 enabled alert sources onto the pin, and the conversion-done pulse.
 assumes the register port is driven on clk by the device's serial
 front end; alert sources and enables come from same-clock logic.
*/
// Contract
// - mask set bits route conditions to pin
// - mask acts only when pin in alert mode
// - bits 23..20 route overcurrent ch1..ch4
// - bits 19..16 route undercurrent ch1..ch4
// - bits 15..12 route overvoltage ch1..ch4
// - bits 11..9 route undervoltage ch1..ch3
// - bit 8 uv ch4, 7..4 overpower
// - bit 3 accumulator, bit 2 count full
// - bit 1: 5us pulse per conversion end
`timescale 1ns/1ps
`include "alert_route_consts.svh"
module alert_pin_one_routing_mask
    import alert_route_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire reg_req_type req,
    input wire alert_src_type tripped,
    input wire alert_src_type enabled,
    input wire logic pin_is_alert,
    input wire logic conversion_end,
    output logic [23:0] rdata_r,
    output logic rvalid_r,
    output logic multifunction_pin_one_r
);
    logic [23:0] alert_pin_one_route_mask_r;
    logic hit;
    logic [21:0] gated;
    // decoded routing fields, one per implemented mask bit
    alert_src_type route_sel;
    logic route_overcurrent_ch_one;
    logic route_overcurrent_ch_two;
    logic route_overcurrent_ch_three;
    logic route_overcurrent_ch_four;
    logic route_undercurrent_ch_one;
    logic route_undercurrent_ch_two;
    logic route_undercurrent_ch_three;
    logic route_undercurrent_ch_four;
    logic route_overvoltage_ch_one;
    logic route_overvoltage_ch_two;
    logic route_overvoltage_ch_three;
    logic route_overvoltage_ch_four;
    logic route_undervoltage_ch_one;
    logic route_undervoltage_ch_two;
    logic route_undervoltage_ch_three;
    logic route_undervoltage_ch_four;
    logic route_overpower_ch_one;
    logic route_overpower_ch_two;
    logic route_overpower_ch_three;
    logic route_overpower_ch_four;
    logic route_accumulator_full;
    logic route_sample_count_full;
    logic conversion_done_pulse_pin_one;
    logic level_nxt;
    logic [`PULSE_CNT_WIDTH-1:0] pulse_cnt_r;
    pulse_state_type pulse_state_r;

    always_comb begin
        if (req.addr == `ROUTE_MASK_OFFSET) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // bit 0 is not implemented and never stores
    always_ff @(posedge clk) begin
        if (reset) begin
            alert_pin_one_route_mask_r <= `ROUTE_MASK_RESET;
        end else if (req.write && hit) begin
            alert_pin_one_route_mask_r <= req.wdata & `ROUTE_MASK_IMPL;
        end
    end

    // unmapped reads answer zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= 24'h000000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= req.read;
            if (req.read && hit) begin
                rdata_r <= alert_pin_one_route_mask_r;
            end else begin
                rdata_r <= 24'h000000;
            end
        end
    end

    // named fields of the mask; bit 0 has no field
    always_comb begin
        // overcurrent group, channel one highest
        route_overcurrent_ch_one =
            alert_pin_one_route_mask_r[`ROUTE_OC_HI];
        route_overcurrent_ch_two =
            alert_pin_one_route_mask_r[`ROUTE_OC_HI - 1];
        route_overcurrent_ch_three =
            alert_pin_one_route_mask_r[`ROUTE_OC_HI - 2];
        route_overcurrent_ch_four =
            alert_pin_one_route_mask_r[`ROUTE_OC_LO];
        // undercurrent group
        route_undercurrent_ch_one =
            alert_pin_one_route_mask_r[`ROUTE_UC_HI];
        route_undercurrent_ch_two =
            alert_pin_one_route_mask_r[`ROUTE_UC_HI - 1];
        route_undercurrent_ch_three =
            alert_pin_one_route_mask_r[`ROUTE_UC_HI - 2];
        route_undercurrent_ch_four =
            alert_pin_one_route_mask_r[`ROUTE_UC_LO];
        // overvoltage group
        route_overvoltage_ch_one =
            alert_pin_one_route_mask_r[`ROUTE_OV_HI];
        route_overvoltage_ch_two =
            alert_pin_one_route_mask_r[`ROUTE_OV_HI - 1];
        route_overvoltage_ch_three =
            alert_pin_one_route_mask_r[`ROUTE_OV_HI - 2];
        route_overvoltage_ch_four =
            alert_pin_one_route_mask_r[`ROUTE_OV_LO];
        // undervoltage group, channel four down at bit 8
        route_undervoltage_ch_one =
            alert_pin_one_route_mask_r[`ROUTE_UV_HI];
        route_undervoltage_ch_two =
            alert_pin_one_route_mask_r[`ROUTE_UV_HI - 1];
        route_undervoltage_ch_three =
            alert_pin_one_route_mask_r[`ROUTE_UV_HI - 2];
        route_undervoltage_ch_four =
            alert_pin_one_route_mask_r[`ROUTE_UV_LO];
        // overpower group
        route_overpower_ch_one =
            alert_pin_one_route_mask_r[`ROUTE_OP_HI];
        route_overpower_ch_two =
            alert_pin_one_route_mask_r[`ROUTE_OP_HI - 1];
        route_overpower_ch_three =
            alert_pin_one_route_mask_r[`ROUTE_OP_HI - 2];
        route_overpower_ch_four =
            alert_pin_one_route_mask_r[`ROUTE_OP_LO];
        // accumulator limits and the conversion-done pulse
        route_accumulator_full =
            alert_pin_one_route_mask_r[`ROUTE_ACC_FULL_BIT];
        route_sample_count_full =
            alert_pin_one_route_mask_r[`ROUTE_COUNT_FULL_BIT];
        conversion_done_pulse_pin_one =
            alert_pin_one_route_mask_r[`ROUTE_CONV_DONE_BIT];
    end

    // channel one at the msb of each group, as in the mask
    always_comb begin
        route_sel.overcurrent = {route_overcurrent_ch_one,
            route_overcurrent_ch_two,
            route_overcurrent_ch_three,
            route_overcurrent_ch_four};
        route_sel.undercurrent = {route_undercurrent_ch_one,
            route_undercurrent_ch_two,
            route_undercurrent_ch_three,
            route_undercurrent_ch_four};
        route_sel.overvoltage = {route_overvoltage_ch_one,
            route_overvoltage_ch_two,
            route_overvoltage_ch_three,
            route_overvoltage_ch_four};
        route_sel.undervoltage = {route_undervoltage_ch_one,
            route_undervoltage_ch_two,
            route_undervoltage_ch_three,
            route_undervoltage_ch_four};
        route_sel.overpower = {route_overpower_ch_one,
            route_overpower_ch_two,
            route_overpower_ch_three,
            route_overpower_ch_four};
        route_sel.accumulator_full = route_accumulator_full;
        route_sel.sample_count_full = route_sample_count_full;
    end

    // enable gating keeps a disabled source off the pin
    always_comb begin
        gated = tripped & enabled;
        gated = gated & route_sel;
    end

    // 5 us pulse; a new conversion end restarts it
    always_ff @(posedge clk) begin
        if (reset) begin
            pulse_state_r <= pulse_idle;
            pulse_cnt_r <= '0;
        end else if (conversion_end && conversion_done_pulse_pin_one) begin
            pulse_state_r <= pulse_high;
            pulse_cnt_r <= `PULSE_CNT_WIDTH'(`CONV_PULSE_CYCLES - 1);
        end else begin
            case (pulse_state_r)
                pulse_high: begin
                    if (pulse_cnt_r == '0) begin
                        pulse_state_r <= pulse_idle;
                    end else begin
                        pulse_cnt_r <= pulse_cnt_r - 1'b1;
                    end
                end
                default: begin
                    pulse_state_r <= pulse_idle;
                end
            endcase
        end
    end

    always_comb begin
        level_nxt = (|gated) || (pulse_state_r == pulse_high);
        level_nxt = level_nxt && pin_is_alert;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            multifunction_pin_one_r <= 1'b0;
        end else begin
            multifunction_pin_one_r <= level_nxt;
        end
    end
endmodule // alert_pin_one_routing_mask

// >>> route_chk.sv
/* route mask checker: assertions on the top ports only, bound below.
 assumes clk and the synchronous active-high reset of the block. */
`timescale 1ns/1ps
module route_chk import alert_route_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire reg_req_type req,
    input wire alert_src_type tripped,
    input wire alert_src_type enabled,
    input wire logic pin_is_alert,
    input wire logic conversion_end,
    input wire logic [23:0] rdata_r,
    input wire logic rvalid_r,
    input wire logic multifunction_pin_one_r);
logic [23:0] m_r;
wire hit = pin_is_alert && |(tripped & enabled & m_r[23:2]);
always_ff @(posedge clk) if (reset) m_r <= 24'h0;
else if (req.write && req.addr == 8'h27) m_r <= req.wdata & 24'hFFFFFE;
default clocking @(posedge clk); endclocking
default disable iff (reset);
property p_rv; req.read |=> rvalid_r; endproperty
a_rv: assert property (p_rv) else $error("rvalid");
property p_rq; !req.read |=> !rvalid_r; endproperty
a_rq: assert property (p_rq) else $error("rvalid");
property p_rd; req.read && req.addr == 8'h27 |=> rdata_r == $past(m_r);
endproperty
a_rd: assert property (p_rd) else $error("rdata");
property p_b0; rvalid_r |-> !rdata_r[0]; endproperty
a_b0: assert property (p_b0) else $error("bit0");
property p_off; !pin_is_alert |=> !multifunction_pin_one_r; endproperty
a_off: assert property (p_off) else $error("mode");
property p_or; hit |=> multifunction_pin_one_r; endproperty
a_or: assert property (p_or) else $error("route");
property p_no; !hit && !m_r[1] |=> !multifunction_pin_one_r; endproperty
a_no: assert property (p_no) else $error("stray");
// the pulse state is registered, then the pin: two edges after the strobe
property p_pu; conversion_end && pin_is_alert && m_r[1] ##1 pin_is_alert
    |=> multifunction_pin_one_r; endproperty
a_pu: assert property (p_pu) else $error("pulse");
endmodule // route_chk
bind alert_pin_one_routing_mask route_chk u_route_chk (.clk(clk),
    .reset(reset), .req(req), .tripped(tripped), .enabled(enabled),
    .pin_is_alert(pin_is_alert), .conversion_end(conversion_end),
    .rdata_r(rdata_r), .rvalid_r(rvalid_r),
    .multifunction_pin_one_r(multifunction_pin_one_r));

// >>> host_pin_watch.sv
/* host model: length of each high run on pin one; same clk */
`timescale 1ns/1ps
module host_pin_watch (
    input wire logic clk,
    input wire logic pin,
    output int run_len);
int cnt = 0;
always @(posedge clk) begin
    cnt = pin ? cnt + 1 : 0;
    if (pin) run_len <= cnt;
end
endmodule // host_pin_watch

// >>> alert_pin_one_routing_mask_bench.sv
/* bench for the route mask: register access, routing per source, pin
 mode, conversion pulse, mid-run reset. inputs change at the falling edge */
`timescale 1ns/1ps
module alert_pin_one_routing_mask_bench import alert_route_pkg::*;;
logic clk = 0, reset = 1, pa = 0, ce = 0, rvalid, pin;
reg_req_type req = '0;
alert_src_type trip = '0, en = '0;
logic [23:0] rdata;
int n_errors = 0, checked = 0, run;
always #12.5 clk = ~clk;
alert_pin_one_routing_mask u_alert_pin_one_routing_mask (.clk(clk),
    .reset(reset), .req(req), .tripped(trip), .enabled(en),
    .pin_is_alert(pa), .conversion_end(ce), .rdata_r(rdata),
    .rvalid_r(rvalid), .multifunction_pin_one_r(pin));
host_pin_watch u_host_pin_watch (.clk(clk), .pin(pin), .run_len(run));
task chk(string s, logic [23:0] e, logic [23:0] g);
    checked++;
    if (g !== e) begin
        n_errors++;
        $display("[FAIL] %s exp %h got %h", s, e, g);
    end
endtask
task test_done;
    if (n_errors == 0 && checked > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
// a spare cycle after each access keeps req single-driven per step
task acc(logic w, logic [7:0] a, logic [23:0] d);
    req = '{w, !w, a, w ? d : 24'h0};
    @(negedge clk) req = '0;
    if (!w) chk("rvalid", 1, rvalid);
    if (!w) chk("rdata", d, rdata);
    @(negedge clk);
endtask
initial begin
    repeat (12) @(negedge clk);
    reset = 0;
    acc(0, 8'h27, 24'h0);
    acc(1, 8'h27, 24'hFFFFFF);
    acc(0, 8'h27, 24'hFFFFFE);
    acc(1, 8'h28, 24'h0);
    acc(0, 8'h27, 24'hFFFFFE);
    acc(0, 8'h28, 24'h0);
    pa = 1;
    // enable first, then route; struct bit k pairs with mask bit k+2
    for (int k = 0; k < 22; k++) begin
        en = 22'h1 << k;
        acc(1, 8'h27, 24'h4 << k);
        trip = en;
        @(negedge clk) chk("route", 1, pin);
        trip = ~trip;
        en = '1;
        @(negedge clk) chk("other", 0, pin);
        trip = ~trip;
        en = ~trip;
        @(negedge clk) chk("disabled", 0, pin);
    end
    en = '0;
    acc(1, 8'h27, 24'hFFFFFC);
    trip = '1;
    en = '1;
    pa = 0;
    @(negedge clk) chk("mode", 0, pin);
    pa = 1;
    @(negedge clk) chk("mode_on", 1, pin);
    trip = '0;
    acc(1, 8'h27, 24'h2);
    ce = 1;
    @(negedge clk) ce = 0;
    for (int i = 0; i < 300 && !pin; i++) @(negedge clk);
    chk("pulse_rise", 1, pin);
    for (int i = 0; i < 300 && pin; i++) @(negedge clk);
    chk("pulse_fall", 0, pin);
    chk("pulse_len", 200, run);
    acc(1, 8'h27, 24'hFFFFFC);
    trip = '1;
    @(negedge clk) chk("pre_reset", 1, pin);
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    chk("reset_pin", 0, pin);
    acc(0, 8'h27, 24'h0);
    chk("reset_route", 0, pin);
    test_done;
end
endmodule // alert_pin_one_routing_mask_bench
